// [bench/scan_port_host.sv]
// host model: serial master of the scan port link
`timescale 1ns/10ps
`default_nettype none
module scan_port_host (
   output logic      sclk,
   output logic      din,
   output logic      chip_select_n,
   input  wire logic dout
);
   initial begin
      sclk = 1'b0;
      din = 1'b0;
      chip_select_n = 1'b1;
   end
   // 320 ns bit time keeps the 11th rise well inside a conversion
   task automatic xfer(input logic [15:0] tx, input int nbits, gap, output logic [15:0] rx);
      rx = 16'h0000;
      #13 chip_select_n = 1'b0;
      #160;
      for (int i = 15; i > 15 - nbits; i--) begin
         if (i == 7) #(gap);
         din = tx[i];
         #80 sclk = 1'b1;
         rx[i] = dout;
         #160 sclk = 1'b0;
         #80;
      end
      #160 chip_select_n = 1'b1;
      // a released line must not show the stale bit
      din = ~din;
   endtask
endmodule
`default_nettype wire

// [bench/scan_port_sva.sv]
// checker on the scan port pins
`timescale 1ns/10ps
`default_nettype none
module scan_port_sva (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       chip_select_n,
   input wire logic       dout_oe,
   input wire logic       conversion_done,
   input wire logic       converting,
   input wire logic [3:0] mux_select
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [11:0] n;
   // length of the running conversion, in clk cycles
   always_ff @(posedge clk or posedge rst)
      if (rst) n <= 12'h000;
      else n <= converting ? n + 12'h001 : 12'h000;
   property p_len; $fell(converting) |-> n >= 12'h44b && n <= 12'h44d; endproperty
   a_len: assert property (p_len) else $error("conversion length wrong");
   property p_done_low; $rose(converting) |-> ##[0:1] !conversion_done; endproperty
   a_done_low: assert property (p_done_low) else $error("done not low");
   property p_done_high; !converting [*3] |-> conversion_done; endproperty
   a_done_high: assert property (p_done_high) else $error("done not high");
   property p_hold; $rose(converting) |-> converting [*8]; endproperty
   a_hold: assert property (p_hold) else $error("conversion cut short");
   property p_oe_on; !chip_select_n [*6] |-> dout_oe; endproperty
   a_oe_on: assert property (p_oe_on) else $error("output not driven");
   property p_oe_off; chip_select_n [*6] |-> !dout_oe; endproperty
   a_oe_off: assert property (p_oe_off) else $error("output not released");
   property p_mux; $changed(mux_select) |-> $rose(converting); endproperty
   a_mux: assert property (p_mux) else $error("select moved off start");
   property p_sel; $rose(converting) |-> !chip_select_n; endproperty
   a_sel: assert property (p_sel) else $error("start outside frame");
endmodule
bind serial_adc_channel_scan_port scan_port_sva chk (.clk, .rst, .chip_select_n, .dout_oe,
   .conversion_done, .converting, .mux_select);
`default_nettype wire

// [bench/serial_adc_channel_scan_port_tb_top.sv]
// self-checking bench for the scan port
`timescale 1ns/10ps
`default_nettype none
module serial_adc_channel_scan_port_tb_top;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        sclk, din, cs_n, dout, oe, done, conv;
   logic [3:0]  mux;
   logic [15:0] rx;
   logic [19:0] rows [14];
   int          fails = 0;
   int          total_checks = 0;
   int          cyc = 0;
   always #20 clk = ~clk;
   serial_adc_channel_scan_port #(.INTERNAL_CLOCK(1'b1)) uut (.clk, .rst, .sclk, .din,
      .chip_select_n(cs_n), .external_conversion_clock(1'b0),
      .conversion_result({mux, mux, 2'h1}), .dout, .dout_oe(oe), .conversion_done(done),
      .converting(conv), .mux_select(mux));
   scan_port_host host (.sclk, .din, .chip_select_n(cs_n), .dout);
   task automatic check(input logic [15:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic frame(input logic [15:0] tx, input int gap);
      host.xfer(tx, 16, gap, rx);
      @(posedge clk);
      while (done !== 1'b1) @(posedge clk);
      #5 check({done, conv}, 16'h0002);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         fails++;
         give_verdict();
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      #5 rst = 1'b0;
      repeat (3) @(posedge clk);
      for (int a = 0; a < 14; a++)
         rows[a] = {4'(a), a < 11 ? {4'(a), 4'(a), 2'h1, 6'h00} : a == 11 ? 16'h8000 :
            a == 12 ? 16'h0000 : 16'hffc0};
      // nibbles E and F are never sent
      for (int i = 0; i < 14; i++) begin
         frame({rows[i][19:16], 12'(i * 291)}, i % 2 ? 1000 : 0);
         check(mux, rows[i][19:16]);
         check(rx, i > 0 ? rows[(i + 13) % 14][15:0] : 16'h0000);
         $display("row %0d done", i);
      end
      // short frame: address dropped, no conversion
      host.xfer(16'h3000, 8, 0, rx);
      repeat (8) @(posedge clk);
      check({conv, rx[15:8]}, 16'h00ff);
      check(mux, 16'h000d);
      host.xfer(16'h2000, 16, 0, rx);
      check(rx >> 6, 16'h03ff);
      @(posedge clk);
      #5 rst = 1'b1;
      @(posedge clk);
      #5 rst = 1'b0;
      check({done, conv, mux}, 16'h0020);
      repeat (3) @(posedge clk);
      frame(16'h7000, 0);
      check(rx, 16'h0000);
      $display("reset and short frame done");
      give_verdict();
   end
endmodule
`default_nettype wire

// [src/link_sync_if.sv]
// synchronised link pins passed from the synchroniser to the port
`timescale 1ns/10ps
`default_nettype none
interface link_sync_if;
   logic sclk;
   logic din;
   logic sel_n;
   logic conv_clk;
   modport source (output sclk, output din, output sel_n, output conv_clk);
   modport sink   (input sclk, input din, input sel_n, input conv_clk);
endinterface
`default_nettype wire

// [src/pin_sync.sv]
// two-flop synchronisers for the link pins
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       sclk_pin,
   input  wire logic       din_pin,
   input  wire logic       sel_n_pin,
   input  wire logic       conv_clk_pin,
   link_sync_if.source     sync
);
   logic [3:0] stage1;
   logic [3:0] stage2;

   // chip select idles high so the port starts deselected
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stage1 <= 4'h2;
         stage2 <= 4'h2;
      end else begin
         stage1 <= {conv_clk_pin, din_pin, sel_n_pin, sclk_pin};
         stage2 <= stage1;
      end
   end

   assign sync.sclk     = stage2[0];
   assign sync.sel_n    = stage2[1];
   assign sync.din      = stage2[2];
   assign sync.conv_clk = stage2[3];
endmodule
`default_nettype wire

// [src/scan_port_pkg.sv]
// constants for the serial converter scan port
// Contract
// [R1] full duplex: old result out, next address in
// [R2] host counts 44 conversion clocks before reading
// [R3] internal variant drives conversion-done output
// [R4] host may service conversion-done as interrupt
// [R5] first four bits are address, rest ignored
// [R6] ten result bits msb first, six zeros
// [R7] one 16-clock stream or two 8-clock bursts
// [R8] nibbles 0 to A select inputs zero-ten
// [R9] nibble B half scale, nibble C zero
// [R10] nibble D gives full scale, all ones
// [R11] host shifts read right six for result
// [R12] eleventh clock rise before conversion completes
// [R13] external variant: 44 conversion clocks, no done
// [R14] host never sends nibbles E or F
package scan_port_pkg;
   localparam int          RESULT_WIDTH   = 10;
   localparam int          ADDR_WIDTH     = 4;
   localparam int          FRAME_BITS     = 16;
   localparam logic [4:0]  ADDR_LAST_BIT  = 5'h04;
   localparam logic [4:0]  RESULT_BITS    = 5'h0a;
   localparam logic [4:0]  FRAME_LAST_BIT = 5'h10;
   localparam int          CLK_MHZ        = 25;
   localparam int          CONV_TIME_US   = 44;
   localparam int          CONV_CYCLES    = CONV_TIME_US * CLK_MHZ;
   localparam logic [10:0] CONV_CYCLES_W  = 11'(CONV_CYCLES);
   localparam logic [10:0] EXT_CONV_EDGES = 11'h02c;
   localparam logic [3:0]  CHAN_LAST_EXT  = 4'ha;
   localparam logic [3:0]  SEL_HALF       = 4'hb;
   localparam logic [3:0]  SEL_ZERO       = 4'hc;
   localparam logic [3:0]  SEL_FULL       = 4'hd;
   localparam logic [9:0]  CODE_HALF      = 10'h200;
   localparam logic [9:0]  CODE_ZERO      = 10'h000;
   localparam logic [9:0]  CODE_FULL      = 10'h3ff;
   localparam logic [5:0]  PAD_ZEROS      = 6'h00;
   localparam logic [3:0]  SEL_RESET      = 4'h0;
endpackage

// [src/serial_adc_channel_scan_port.sv]
// serial command and result port of the scanning converter
`timescale 1ns/10ps
`default_nettype none
module serial_adc_channel_scan_port #(
   parameter bit INTERNAL_CLOCK = 1'b1
) (
   input  wire logic                                    clk,
   input  wire logic                                    rst,
   input  wire logic                                    sclk,
   input  wire logic                                    din,
   input  wire logic                                    chip_select_n,
   input  wire logic                                    external_conversion_clock,
   input  wire logic [scan_port_pkg::RESULT_WIDTH-1:0]  conversion_result,
   output logic                                         dout,
   output logic                                         dout_oe,
   output logic                                         conversion_done,
   output logic                                         converting,
   output logic [scan_port_pkg::ADDR_WIDTH-1:0]         mux_select
);
   import scan_port_pkg::*;

   link_sync_if sync ();

   pin_sync u_sync (
      .clk          (clk),
      .rst          (rst),
      .sclk_pin     (sclk),
      .din_pin      (din),
      .sel_n_pin    (chip_select_n),
      .conv_clk_pin (external_conversion_clock),
      .sync         (sync)
   );

   // edge detection on the synchronised pins
   logic                    sclk_prev;
   logic                    sel_n_prev;
   logic                    conv_clk_prev;
   logic                    sclk_rise;
   logic                    sclk_fall;
   logic                    frame_start;
   logic                    active;

   // frame bookkeeping and shift registers
   logic [4:0]              rise_count;
   logic [ADDR_WIDTH-1:0]   addr_shift;
   logic [FRAME_BITS-1:0]   out_shift;

   // conversion timing and result
   logic                    conv_tick;
   logic [RESULT_WIDTH-1:0] result_hold;
   logic [10:0]             conv_count;
   logic                    start_conv;
   logic [RESULT_WIDTH-1:0] next_result;

   // link clock idles low, so no false rise after reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sclk_prev <= 1'b0;
      end else begin
         sclk_prev <= sync.sclk;
      end
   end

   // deselected after reset, so no false frame start
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sel_n_prev <= 1'b1;
      end else begin
         sel_n_prev <= sync.sel_n;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         conv_clk_prev <= 1'b0;
      end else begin
         conv_clk_prev <= sync.conv_clk;
      end
   end

   // sclk must stay below clk/6 or edges slip between samples
   assign active      = ~sync.sel_n;
   assign frame_start = sel_n_prev & ~sync.sel_n;
   assign sclk_rise   = active & sync.sclk & ~sclk_prev;
   assign sclk_fall   = active & ~sync.sclk & sclk_prev;

   // internal variant ticks every clock; external counts pin rises
   always_comb begin
      if (INTERNAL_CLOCK) begin
         conv_tick = 1'b1;
      end else begin
         conv_tick = sync.conv_clk & ~conv_clk_prev;
      end
   end

   // conversion launches on the falling clock that ends the tenth bit
   assign start_conv  = sclk_fall & (rise_count == RESULT_BITS);

   // rise counter survives a pause between two 8-bit bursts [R7]
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rise_count <= 5'h00;
      end else if (frame_start) begin
         rise_count <= 5'h00;
      end else if (sclk_rise && rise_count != FRAME_LAST_BIT) begin
         rise_count <= rise_count + 5'h01;
      end
   end

   // only the first four bits in, msb first, form the address [R5] [R1]
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         addr_shift <= SEL_RESET;
      end else if (sclk_rise && rise_count < ADDR_LAST_BIT) begin
         addr_shift <= {addr_shift[ADDR_WIDTH-2:0], sync.din};
      end
   end

   // previous result out msb first, then six zeros [R6] [R1]
   // loaded once per frame; a fresher result waits for the next frame
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         out_shift <= '0;
      end else if (frame_start) begin
         out_shift <= {result_hold, PAD_ZEROS};
      end else if (sclk_fall) begin
         out_shift <= {out_shift[FRAME_BITS-2:0], 1'b0};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dout <= 1'b0;
      end else if (frame_start) begin
         dout <= result_hold[RESULT_WIDTH-1];
      end else if (sclk_fall) begin
         dout <= out_shift[FRAME_BITS-2];
      end
   end

   // enable follows the synchronised select, so it lags the pin
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dout_oe <= 1'b0;
      end else begin
         dout_oe <= active;
      end
   end

   // select moves only when a conversion starts
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mux_select <= SEL_RESET;
      end else if (start_conv) begin
         mux_select <= addr_shift;
      end
   end

   // test selects bypass the converter input [R8] [R9] [R10]
   always_comb begin
      unique case (mux_select)
         4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
         4'h6, 4'h7, 4'h8, 4'h9, 4'ha: begin
            next_result = conversion_result;
         end
         SEL_HALF: begin
            next_result = CODE_HALF;
         end
         SEL_ZERO: begin
            next_result = CODE_ZERO;
         end
         SEL_FULL: begin
            next_result = CODE_FULL;
         end
         // E and F select nothing; read as zero
         default: begin
            next_result = CODE_ZERO;
         end
      endcase
   end

   // internal timer or 44 sampled external clock edges [R13] [R2]
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         conv_count <= 11'h000;
      end else if (start_conv) begin
         conv_count <= INTERNAL_CLOCK ? CONV_CYCLES_W : EXT_CONV_EDGES;
      end else if (converting && conv_tick) begin
         conv_count <= conv_count - 11'h001;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         converting <= 1'b0;
      end else if (start_conv) begin
         converting <= 1'b1;
      end else if (converting && conv_tick && conv_count == 11'h001) begin
         converting <= 1'b0;
      end
   end

   // held result reaches dout only at the next frame start
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         result_hold <= CODE_ZERO;
      end else if (converting && conv_tick && conv_count == 11'h001) begin
         result_hold <= next_result;
      end
   end

   // done low through the conversion interval; held high when external [R3]
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         conversion_done <= 1'b1;
      end else if (!INTERNAL_CLOCK) begin
         conversion_done <= 1'b1;
      end else if (start_conv) begin
         conversion_done <= 1'b0;
      end else if (converting && conv_count == 11'h001) begin
         conversion_done <= 1'b1;
      end
   end
endmodule
`default_nettype wire
